// ==== logic/cds_pkg.sv ====
// Package for the complement/decrement/skip execution block
package cds_pkg;
  localparam int DATA_W = 8;
  localparam int INSN_W = 14;
  localparam int FADDR_W = 7;
  localparam logic [5:0] OPC_COMPLEMENT = 6'h09;
  localparam logic [5:0] OPC_DECREMENT = 6'h03;
  localparam logic [5:0] OPC_DEC_SKIP = 6'h0b;
  localparam int OPC_HI = 13;
  localparam int OPC_LO = 8;
  localparam int DEST_BIT = 7;
  localparam logic [6:0] TIMER_COUNT_ADDR = 7'h01;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [7:0] ONE = 8'h01;

  typedef enum logic [1:0] {PH_DECODE, PH_READ, PH_COMPUTE, PH_WRITE} cds_phase_t;
  typedef enum logic [1:0] {OP_NONE, OP_COMP, OP_DEC, OP_DECSKIP} cds_op_t;

  typedef struct packed {
    logic [6:0] addr;
    logic we;
    logic [7:0] data;
  } cds_fwr_t;

  typedef struct packed {
    cds_phase_t phase;
    cds_op_t op;
    logic dest_file;
    logic [6:0] addr;
    logic is_port;
    logic [7:0] operand;
    logic [7:0] result;
    logic [7:0] acc;
    logic zero;
    logic skip_pend;
    logic nop_cycle;
    cds_fwr_t fwr;
    logic presc_clr;
    logic cycle_done;
    logic [7:0] pin_s1;
    logic [7:0] pin_s2;
  } cds_state_t;
endpackage

// ==== logic/cds_exec.sv ====
// Execution logic for complement, decrement and decrement-with-skip
`timescale 1ns/1ps
`default_nettype none

module cds_exec #(
  parameter int DATA_W = cds_pkg::DATA_W,
  parameter int INSN_W = cds_pkg::INSN_W,
  parameter int FADDR_W = cds_pkg::FADDR_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Instruction, operand and pin inputs
  input wire logic [INSN_W-1:0] insn,
  input wire logic [DATA_W-1:0] file_rdata,
  input wire logic [DATA_W-1:0] pin_levels,
  input wire logic [FADDR_W-1:0] port_addr_a,
  input wire logic [FADDR_W-1:0] port_addr_b,
  input wire logic presc_to_watchdog,
  // Results and cycle status
  output logic [FADDR_W-1:0] file_raddr,
  output logic [DATA_W-1:0] acc,
  output logic zero_flag,
  output logic cycle_done,
  output logic skip_next,
  output logic nop_cycle,
  output logic presc_clear,
  output var cds_pkg::cds_fwr_t file_wr
);

  // State record and its next value
  cds_pkg::cds_state_t s_r;
  cds_pkg::cds_state_t s_nxt;

  // Fields of the incoming instruction word
  logic [5:0] opc_w;
  logic dest_w;
  logic [FADDR_W-1:0] index_w;
  logic port_hit_w;

  // Reset image of the state record
  localparam cds_pkg::cds_state_t S_RESET = '{
    phase: cds_pkg::PH_DECODE,
    op: cds_pkg::OP_NONE,
    acc: cds_pkg::ACC_RESET,
    fwr: '0,
    default: '0
  };

  // The state record is laid out for the package widths only
  if (DATA_W != cds_pkg::DATA_W) begin : g_chk_data_w
    $error("cds_exec: data width differs from the package");
  end
  if (INSN_W != cds_pkg::INSN_W) begin : g_chk_insn_w
    $error("cds_exec: instruction width differs from the package");
  end
  if (FADDR_W != cds_pkg::FADDR_W) begin : g_chk_faddr_w
    $error("cds_exec: register index width differs from the package");
  end
  if (cds_pkg::OPC_HI - cds_pkg::OPC_LO != 5) begin : g_chk_opc
    $error("cds_exec: opcode field must be six bits wide");
  end
  if (cds_pkg::DEST_BIT != FADDR_W) begin : g_chk_dest
    $error("cds_exec: destination bit must sit above the index");
  end
  if (cds_pkg::OPC_COMPLEMENT == cds_pkg::OPC_DECREMENT ||
      cds_pkg::OPC_COMPLEMENT == cds_pkg::OPC_DEC_SKIP ||
      cds_pkg::OPC_DECREMENT == cds_pkg::OPC_DEC_SKIP) begin : g_chk_codes
    $error("cds_exec: opcodes must be distinct");
  end

  function automatic cds_pkg::cds_op_t decode_op(input logic [5:0] opc);
    unique case (opc)
      cds_pkg::OPC_COMPLEMENT: decode_op = cds_pkg::OP_COMP;
      cds_pkg::OPC_DECREMENT: decode_op = cds_pkg::OP_DEC;
      cds_pkg::OPC_DEC_SKIP: decode_op = cds_pkg::OP_DECSKIP;
      default: decode_op = cds_pkg::OP_NONE;
    endcase
  endfunction

  // True when the index names one of the two port registers
  function automatic logic is_port_addr(
    input logic [6:0] idx,
    input logic [6:0] pa,
    input logic [6:0] pb
  );
    is_port_addr = (idx == pa) || (idx == pb);
  endfunction

  // Bitwise complement of an operand
  function automatic logic [7:0] complement_of(input logic [7:0] v);
    complement_of = ~v;
  endfunction

  // Operand minus one, wrapping from zero to all ones
  function automatic logic [7:0] decrement_of(input logic [7:0] v);
    decrement_of = v - cds_pkg::ONE;
  endfunction

  // Zero test shared by the flag and the skip decision
  function automatic logic is_null(input logic [7:0] v);
    is_null = (v == 8'h00);
  endfunction

  // Prescaler clear: timer count written while the timer owns it
  function automatic logic clears_presc(
    input logic [6:0] idx,
    input logic to_watchdog
  );
    clears_presc = (idx == cds_pkg::TIMER_COUNT_ADDR) && !to_watchdog;
  endfunction

  assign opc_w = insn[cds_pkg::OPC_HI:cds_pkg::OPC_LO];
  assign dest_w = insn[cds_pkg::DEST_BIT];
  assign index_w = insn[FADDR_W-1:0];
  assign port_hit_w = is_port_addr(index_w, port_addr_a, port_addr_b);

  always_comb begin
    s_nxt = s_r;
    s_nxt.fwr.we = 1'b0;
    s_nxt.presc_clr = 1'b0;
    s_nxt.cycle_done = 1'b0;
    // Pins pass two flip-flops before the operand mux sees them
    s_nxt.pin_s1 = pin_levels;
    s_nxt.pin_s2 = s_r.pin_s1;
    unique case (s_r.phase)
      cds_pkg::PH_DECODE: begin
        s_nxt.phase = cds_pkg::PH_READ;
        if (s_r.skip_pend) begin
          // Discarded instruction, cycle runs as a no-operation
          s_nxt.op = cds_pkg::OP_NONE;
          s_nxt.nop_cycle = 1'b1;
          s_nxt.skip_pend = 1'b0;
        end else begin
          s_nxt.op = decode_op(opc_w);
          s_nxt.nop_cycle = 1'b0;
        end
        s_nxt.dest_file = dest_w;
        s_nxt.addr = index_w;
        s_nxt.is_port = port_hit_w;
      end
      cds_pkg::PH_READ: begin
        s_nxt.phase = cds_pkg::PH_COMPUTE;
        if (s_r.is_port) begin
          s_nxt.operand = s_r.pin_s2;
        end else begin
          s_nxt.operand = file_rdata;
        end
      end
      cds_pkg::PH_COMPUTE: begin
        s_nxt.phase = cds_pkg::PH_WRITE;
        unique case (s_r.op)
          cds_pkg::OP_COMP: begin
            s_nxt.result = complement_of(s_r.operand);
          end
          cds_pkg::OP_DEC: begin
            s_nxt.result = decrement_of(s_r.operand);
          end
          cds_pkg::OP_DECSKIP: begin
            s_nxt.result = decrement_of(s_r.operand);
          end
          cds_pkg::OP_NONE: begin
            s_nxt.result = s_r.operand;
          end
        endcase
      end
      cds_pkg::PH_WRITE: begin
        s_nxt.phase = cds_pkg::PH_DECODE;
        s_nxt.cycle_done = 1'b1;
        if (s_r.op != cds_pkg::OP_NONE) begin
          if (s_r.dest_file) begin
            s_nxt.fwr.we = 1'b1;
            s_nxt.fwr.addr = s_r.addr;
            s_nxt.fwr.data = s_r.result;
            s_nxt.presc_clr = clears_presc(s_r.addr, presc_to_watchdog);
          end else begin
            s_nxt.acc = s_r.result;
          end
          if (s_r.op == cds_pkg::OP_DECSKIP) begin
            // Flags stay as they are, only the skip is decided
            s_nxt.skip_pend = is_null(s_r.result);
          end else begin
            s_nxt.zero = is_null(s_r.result);
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_r <= S_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Registered data outputs
  assign file_raddr = s_r.addr;
  assign acc = s_r.acc;
  assign zero_flag = s_r.zero;
  assign file_wr = s_r.fwr;

  // Registered cycle status and pulses
  assign cycle_done = s_r.cycle_done;
  assign skip_next = s_r.skip_pend;
  assign nop_cycle = s_r.nop_cycle;
  assign presc_clear = s_r.presc_clr;
endmodule

`default_nettype wire

// ==== verif/cds_exec_properties.sv ====
// Checker for the execution block
`timescale 1ns/1ps
`default_nettype none
module cds_exec_chk (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [13:0] insn,
  input wire logic [7:0] file_rdata,
  input wire logic [7:0] pin_levels,
  input wire logic [6:0] port_addr_a,
  input wire logic [6:0] port_addr_b,
  input wire logic [7:0] acc,
  input wire logic zero_flag,
  input wire logic cycle_done,
  input wire logic nop_cycle,
  input wire logic presc_clear,
  input wire cds_pkg::cds_fwr_t file_wr
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  logic [55:0] ih;
  logic [23:0] rh;
  logic [2:0] nh;
  logic [39:0] ph;
  always_ff @(posedge clk) begin
    ih <= {ih[41:0], insn};
    ph <= {ph[31:0], pin_levels};
    rh <= {rh[15:0], file_rdata};
    nh <= {nh[1:0], nop_cycle};
  end
  wire pt = ih[48:42] == port_addr_a || ih[48:42] == port_addr_b;
  wire [7:0] f = pt ? ph[39:32] : rh[23:16];
  wire [7:0] m = f - 8'h01;
  wire d = ih[49];
  wire c = cycle_done & ~nh[2];
  wire cm = c && ih[55:50] == 6'h09;
  wire dc = c && ih[55:50] == 6'h03;
  wire sk = c && ih[55:50] == 6'h0b;
  property p_comp; cm |-> (d ? file_wr.data : acc) == ~f; endproperty
  a_comp: assert property (p_comp) else $error("comp");
  property p_dest; cm || dc |-> file_wr.we == d; endproperty
  a_dest: assert property (p_dest) else $error("dest");
  property p_dec; dc |-> (d ? file_wr.data : acc) == m; endproperty
  a_dec: assert property (p_dec) else $error("dec");
  property p_zero; cm || dc |-> zero_flag == (cm ? f == 8'hff : m == 8'h00); endproperty
  a_zero: assert property (p_zero) else $error("zero");
  property p_keep; sk |-> $stable(zero_flag); endproperty
  a_keep: assert property (p_keep) else $error("keep");
  property p_skd; sk |-> (d ? file_wr.we && file_wr.data == m : acc == m); endproperty
  a_skd: assert property (p_skd) else $error("skd");
  property p_skip; sk && m == 8'h00 |-> ##2 nop_cycle; endproperty
  a_skip: assert property (p_skip) else $error("skip");
  property p_prc; presc_clear |-> file_wr.we && file_wr.addr == 7'h01; endproperty
  a_prc: assert property (p_prc) else $error("prc");
endmodule
bind cds_exec cds_exec_chk u_chk (.clk, .rstn, .insn, .file_rdata, .pin_levels, .port_addr_a,
  .port_addr_b, .acc, .zero_flag,
  .cycle_done, .nop_cycle, .presc_clear, .file_wr);
`default_nettype wire

// ==== verif/test_cds_exec.sv ====
// Bench for the execution block
`timescale 1ns/1ps
`default_nettype none
module test_cds_exec;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [13:0] insn = 14'h0000;
  logic [7:0] file_rdata = 8'h00;
  logic [7:0] pins = 8'h3c;
  logic wd = 1'b0;
  logic [6:0] raddr;
  logic [7:0] acc;
  logic zf, done, skip, nop, pclr;
  cds_pkg::cds_fwr_t fw;
  int miscompares = 0;
  int n_tests = 0;
  int cyc = 0;
  always #5 clk = ~clk;
  cds_exec dut_u (.clk, .rstn, .insn, .file_rdata, .pin_levels(pins), .port_addr_a(7'h7e),
    .port_addr_b(7'h7f), .presc_to_watchdog(wd), .file_raddr(raddr), .acc, .zero_flag(zf),
    .cycle_done(done), .skip_next(skip), .nop_cycle(nop), .presc_clear(pclr), .file_wr(fw));
  task automatic ck(input logic [7:0] s, input logic [7:0] e);
    n_tests++;
    if (s !== e) begin
      miscompares++;
      $display("mismatch %0t %h %h", $time, s, e);
    end
  endtask
  task automatic ex(input logic [5:0] o, input logic d, input logic [6:0] a, input logic [7:0] f);
    insn = {o, d, a};
    file_rdata = f;
    repeat (4) @(posedge clk);
    #1;
    ck({7'h00, done}, 8'h01);
    ck({1'b0, raddr}, {1'b0, a});
  endtask
  task t_comp;
    ex(6'h09, 1'b1, 7'h20, 8'h5a);
    ck(fw.data, 8'ha5);
    ck({1'b0, fw.addr}, 8'h20);
    ck({7'h00, fw.we}, 8'h01);
    ck({7'h00, zf}, 8'h00);
    ex(6'h09, 1'b0, 7'h21, 8'hff);
    ck({7'h00, fw.we}, 8'h00);
    ck(acc, 8'h00);
    ck({7'h00, zf}, 8'h01);
  endtask
  task t_port;
    ex(6'h09, 1'b1, 7'h7e, 8'h00);
    ck(fw.data, 8'hc3);
    ex(6'h03, 1'b0, 7'h7f, 8'hff);
    ck(acc, 8'h3b);
  endtask
  task t_dec;
    ex(6'h03, 1'b1, 7'h01, 8'h00);
    ck(fw.data, 8'hff);
    ck({7'h00, pclr}, 8'h01);
    ck({7'h00, zf}, 8'h00);
    ex(6'h03, 1'b1, 7'h22, 8'h01);
    ck(fw.data, 8'h00);
    ck({7'h00, zf}, 8'h01);
    ck({7'h00, pclr}, 8'h00);
    wd = 1'b1;
    ex(6'h03, 1'b0, 7'h01, 8'h05);
    ck(acc, 8'h04);
    ck({7'h00, pclr}, 8'h00);
    ck({7'h00, zf}, 8'h00);
    wd = 1'b0;
  endtask
  task t_skip;
    ex(6'h0b, 1'b0, 7'h24, 8'h01);
    ck(acc, 8'h00);
    ck({7'h00, zf}, 8'h00);
    ck({7'h00, skip}, 8'h01);
    ex(6'h09, 1'b1, 7'h25, 8'h00);
    ck({7'h00, fw.we}, 8'h00);
    ck({7'h00, nop}, 8'h01);
    ck(acc, 8'h00);
    ex(6'h0b, 1'b1, 7'h26, 8'h03);
    ck({7'h00, nop}, 8'h00);
    ck({7'h00, fw.we}, 8'h01);
    ck(fw.data, 8'h02);
    ck({7'h00, skip}, 8'h00);
  endtask
  task tally_and_finish;
    $display("tests %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 500) begin
      miscompares++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    #1 rstn = 1;
    t_comp();
    t_port();
    t_dec();
    t_skip();
    tally_and_finish();
  end
endmodule
`default_nettype wire
